// ---- tsm_pkg.sv ----
// Package of constants for the thermal shutdown monitor
package tsm_pkg;
  localparam int          TSM_DATA_W       = 16;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  TSM_IDX_OUT_PWR  = 8'h01;
  localparam logic [7:0]  TSM_IDX_IN_PWR   = 8'h02;
  localparam logic [7:0]  TSM_IDX_STATUS   = 8'h03;
  localparam logic [7:0]  TSM_IDX_IRQ_STAT = 8'h04;
  localparam logic [7:0]  TSM_IDX_IRQ_MASK = 8'h05;
  localparam logic [7:0]  TSM_IDX_PIN_CTRL = 8'h06;
  localparam logic [15:0] TSM_OUT_PWR_RST  = 16'h0000;
  localparam logic [15:0] TSM_IN_PWR_RST   = 16'h6000;
  localparam logic [15:0] TSM_IRQ_MASK_RST = 16'h0000;
  localparam logic [15:0] TSM_PIN_CTRL_RST = 16'h0000;
  // Field positions
  localparam int          TSM_BIT_SPK_R    = 13;
  localparam int          TSM_BIT_SPK_L    = 12;
  localparam int          TSM_BIT_SENS_EN  = 14;
  localparam int          TSM_BIT_CUT      = 13;
  localparam int          TSM_BIT_TEMP_OK  = 0;
  localparam int          TSM_BIT_SHUT     = 1;
  localparam int          TSM_BIT_OK_LOST  = 0;
  localparam int          TSM_BIT_OK_BACK  = 1;
  localparam int          TSM_BIT_PIN_SEL  = 0;
  localparam int          TSM_BIT_PIN_INV  = 1;
endpackage : tsm_pkg

// ---- tsm_monitor.sv ----
// Thermal shutdown monitor with APB register slave
`timescale 1ns/1ns
`default_nettype none
module tsm_monitor
  import tsm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sensor_overheat,
  output logic             sensor_enable,
  output logic             left_speaker_out,
  output logic             right_speaker_out,
  output logic             first_general_pin,
  output logic             irq
);

  // Sensor pin synchroniser
  logic        ovh_meta;
  logic        ovh_sync;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovh_meta <= 1'b0;
      ovh_sync <= 1'b0;
    end else begin
      ovh_meta <= sensor_overheat;
      ovh_sync <= ovh_meta;
    end
  end

  logic [15:0] output_power_enables;
  logic [15:0] input_power_and_thermal;
  logic [15:0] irq_status;
  logic [15:0] irq_mask;
  logic [15:0] pin_ctrl;
  logic        temp_ok;

  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a[1:0] == 2'b00) && (a[11:2] == {2'b00, idx});
  endfunction : hit

  wire         acc        = psel & penable;
  wire         wr         = acc & pwrite;
  wire         lo_ok      = pstrb[0];
  wire         hi_ok      = pstrb[1];
  wire         sel_out    = hit(paddr, TSM_IDX_OUT_PWR);
  wire         sel_in     = hit(paddr, TSM_IDX_IN_PWR);
  wire         sel_stat   = hit(paddr, TSM_IDX_STATUS);
  wire         sel_istat  = hit(paddr, TSM_IDX_IRQ_STAT);
  wire         sel_imask  = hit(paddr, TSM_IDX_IRQ_MASK);
  wire         sel_pin    = hit(paddr, TSM_IDX_PIN_CTRL);
  wire         mapped     = sel_out | sel_in | sel_stat | sel_istat | sel_imask | sel_pin;
  wire [15:0]  wmask      = {{8{hi_ok}}, {8{lo_ok}}};
  wire [15:0]  wdata      = pwdata[15:0];

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [15:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  // Thermal controls
  wire         sens_en    = input_power_and_thermal[TSM_BIT_SENS_EN];
  wire         cut_en     = input_power_and_thermal[TSM_BIT_CUT];
  wire         overheat   = sens_en & ovh_sync;
  wire         shut_now   = sens_en & cut_en & overheat;
  wire         next_temp_ok = ~overheat;

  // Events: flag lost and flag restored
  wire         ev_lost    = temp_ok & ~next_temp_ok;
  wire         ev_back    = ~temp_ok & next_temp_ok;
  wire [15:0]  ev_vec     = (16'h0001 << TSM_BIT_OK_LOST) & {16{ev_lost}}
                          | (16'h0001 << TSM_BIT_OK_BACK) & {16{ev_back}};
  wire [15:0]  w1c        = (wr & sel_istat) ? (wdata & wmask) : 16'h0000;
  wire [15:0]  next_irq_status = (irq_status & ~w1c) | ev_vec;         // Set beats clear
  wire         next_irq   = |(next_irq_status & irq_mask);

  wire [15:0]  spk_bits   = (16'h0001 << TSM_BIT_SPK_L) | (16'h0001 << TSM_BIT_SPK_R);
  wire         left_req   = output_power_enables[TSM_BIT_SPK_L];
  wire         right_req  = output_power_enables[TSM_BIT_SPK_R];
  wire         next_left  = left_req & ~shut_now;
  wire         next_right = right_req & ~shut_now;
  wire         pin_src    = next_temp_ok ^ pin_ctrl[TSM_BIT_PIN_INV];
  wire         next_pin   = pin_ctrl[TSM_BIT_PIN_SEL] & pin_src;

  wire [15:0]  status_word = ({15'h0000, temp_ok} << TSM_BIT_TEMP_OK)
                           | ({15'h0000, shut_now} << TSM_BIT_SHUT);
  wire [15:0]  rd_word =
      sel_out   ? output_power_enables    :
      sel_in    ? input_power_and_thermal :
      sel_stat  ? status_word             :
      sel_istat ? irq_status              :
      sel_imask ? irq_mask                :
      sel_pin   ? pin_ctrl                : 16'h0000;

  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_power_enables    <= TSM_OUT_PWR_RST;
      input_power_and_thermal <= TSM_IN_PWR_RST;
      irq_mask                <= TSM_IRQ_MASK_RST;
      pin_ctrl                <= TSM_PIN_CTRL_RST;
    end else if (wr) begin
      if (sel_out) output_power_enables <= merge(output_power_enables, wdata, wmask & spk_bits);
      if (sel_in)  input_power_and_thermal <= merge(input_power_and_thermal, wdata, wmask);
      if (sel_imask) irq_mask <= merge(irq_mask, wdata, wmask & 16'h0003);
      if (sel_pin)   pin_ctrl <= merge(pin_ctrl, wdata, wmask & 16'h0003);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 16'h0000;
      temp_ok    <= 1'b1;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      temp_ok    <= next_temp_ok;
      irq        <= next_irq;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_speaker_out  <= 1'b0;
      right_speaker_out <= 1'b0;
      first_general_pin <= 1'b0;
      sensor_enable     <= 1'b0;
    end else begin
      left_speaker_out  <= next_left;
      right_speaker_out <= next_right;
      first_general_pin <= next_pin;
      sensor_enable     <= sens_en;
    end
  end

  // APB answer: zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? {16'h0000, rd_word} : 32'h0000_0000;
    end
  end
endmodule : tsm_monitor
`default_nettype wire

// ---- tsm_monitor_assertions.sv ----
// Port-level assertions for the thermal shutdown monitor
`timescale 1ns/1ns
`default_nettype none
module tsm_monitor_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sensor_overheat,
  input wire logic        sensor_enable,
  input wire logic        left_speaker_out,
  input wire logic        right_speaker_out,
  input wire logic        first_general_pin,
  input wire logic        irq
);
  logic [1:0] cut_q;
  logic [1:0] spk_q;
  logic [1:0] mask_q;
  wire        wr      = psel && penable && pready && pwrite;
  wire        en_cut  = cut_q == 2'h3;
  wire        rd_stat = psel && penable && pready && !pwrite && paddr == 12'h00C;
  // Shadow copies of the control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cut_q  <= 2'h3;
      spk_q  <= 2'h0;
      mask_q <= 2'h0;
    end else if (wr && pstrb[1] && paddr == 12'h008) cut_q <= pwdata[14:13];
    else if (wr && pstrb[1] && paddr == 12'h004) spk_q <= pwdata[13:12];
    else if (wr && pstrb[0] && paddr == 12'h014) mask_q <= pwdata[1:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_pulse: assert property (psel && !penable |=> pready) else $error("no ready");
  a_status_read: assert property ((sensor_enable && sensor_overheat)[*6] ##0 rd_stat |->
    !prdata[0]) else $error("flag not low");
  a_irq_masked: assert property ((mask_q == 2'h0)[*2] |-> !irq) else $error("masked irq");
  a_trip_cut: assert property ((en_cut && sensor_overheat)[*4] |=>
    !left_speaker_out && !right_speaker_out) else $error("speakers not cut");
  a_sensor_bit: assert property (wr && pstrb[1] && paddr == 12'h008 |=> ##1
    sensor_enable == $past(pwdata[14], 2)) else $error("sensor bit");
  a_cut_gate: assert property ((!en_cut && spk_q[0])[*4] |=> left_speaker_out)
    else $error("speaker cut without enable");
  a_hold_off: assert property ((en_cut && sensor_overheat)[*4] ##1 (wr && paddr == 12'h004)
    |=> !left_speaker_out && !right_speaker_out) else $error("speaker reenabled");
  cover property ((en_cut && sensor_overheat)[*4]);
  cover property (irq);
  cover property (pready && pslverr);
endmodule : tsm_monitor_assertions
bind tsm_monitor tsm_monitor_assertions u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sensor_overheat(sensor_overheat), .sensor_enable(sensor_enable),
  .left_speaker_out(left_speaker_out), .right_speaker_out(right_speaker_out),
  .first_general_pin(first_general_pin), .irq(irq));
`default_nettype wire

// ---- thermal_shutdown_monitor_test.sv ----
// Self-checking testbench for the thermal shutdown monitor
`timescale 1ns/1ns
`default_nettype none
module thermal_shutdown_monitor_test;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        sensor_overheat = 1'h0, rerr;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, sensor_enable, left_speaker_out, right_speaker_out;
  logic        first_general_pin, irq;
  int          n_mismatch = 0, check_count = 0, cycles = 0;
  tsm_monitor DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sensor_overheat(sensor_overheat), .sensor_enable(sensor_enable),
    .left_speaker_out(left_speaker_out), .right_speaker_out(right_speaker_out),
    .first_general_pin(first_general_pin), .irq(irq));
  initial forever #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : xfer
  function automatic logic [31:0] spk();
    return {30'h0, right_speaker_out, left_speaker_out};
  endfunction : spk
  task automatic t_reset();
    xfer(1'h0, 12'h004, 32'h0); chk("out_pwr", 32'h0000, rdat);
    xfer(1'h0, 12'h008, 32'h0); chk("in_pwr", 32'h6000, rdat);
    chk("sensor_enable", 32'h1, {31'h0, sensor_enable});
    xfer(1'h0, 12'h00C, 32'h0); chk("status", 32'h1, rdat);
    xfer(1'h0, 12'h040, 32'h0); chk("unmapped", 32'h1, rdat | {31'h0, rerr});
  endtask : t_reset
  task automatic t_trip();
    xfer(1'h1, 12'h004, 32'h3000); cyc(3); chk("spk_on", 32'h3, spk());
    sensor_overheat <= 1'h1;
    cyc(6); chk("spk_cut", 32'h0, spk());
    xfer(1'h0, 12'h00C, 32'h0); chk("status_hot", 32'h2, rdat);
    chk("irq_masked", 32'h0, {31'h0, irq});
    xfer(1'h1, 12'h004, 32'h3000); cyc(4); chk("spk_held", 32'h0, spk());
    xfer(1'h1, 12'h014, 32'h3); cyc(5); chk("irq_set", 32'h1, {31'h0, irq});
    xfer(1'h1, 12'h010, 32'h3); cyc(5); chk("irq_clr", 32'h0, {31'h0, irq});
    xfer(1'h1, 12'h018, 32'h1); cyc(3); chk("pin_hot", 32'h0, {31'h0, first_general_pin});
  endtask : t_trip
  task automatic t_cut();
    xfer(1'h1, 12'h004, 32'h0);
    xfer(1'h1, 12'h008, 32'h4000);
    xfer(1'h1, 12'h004, 32'h3000); cyc(5); chk("spk_nocut", 32'h3, spk());
    xfer(1'h1, 12'h004, 32'h0);
    xfer(1'h1, 12'h008, 32'h2000); cyc(3); chk("sens_off", 32'h0, {31'h0, sensor_enable});
    xfer(1'h0, 12'h00C, 32'h0); chk("status_off", 32'h1, rdat);
    chk("pin_ok", 32'h1, {31'h0, first_general_pin});
  endtask : t_cut
  task automatic complete_run();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  initial begin
    cyc(4);
    presetn <= 1'h1;
    t_reset();
    t_trip();
    t_cut();
    complete_run();
  end
endmodule : thermal_shutdown_monitor_test
`default_nettype wire
